// *** design/pin_sync.sv ***
/*
  Three-stage synchroniser for pin inputs with agreement filter.
  Assumes input is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import sram_host_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3, next_dout;

  always_comb begin
    next_dout = dout;
    // Accept only when stages two and three agree
    if (s2 == s3) begin
      next_dout = s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** design/sram_host.sv ***
/*
  Host controller for an asynchronous 512K x 8 static memory: one-request
  user port, sequences read and write cycles on the memory pins.
  Assumes a memory that keeps its own timing; data pins are split into
  in/out/enable and resolved outside.
*/
// Operation
// R1: A write happens only while select and strobe are both low.
// R2: Strobe stays high through every read cycle.
// R3: Address is valid no later than select falling on reads.
// R4: With drive enable low, write pulse covers float delay plus data setup.
// R5: With drive enable high, write pulse needs only its minimum width.
// R6: Host never drives data while the memory may still drive.
// R7: Select falling with or after strobe keeps memory outputs floating.
// R8: Select held active at least its minimum before write end.
// R9: Read cycle lasts at least minimum; data valid after access time.
// R10: Memory waits after select falls before driving data.
// R11: Memory floats data within its limit after select rises.
// R12: Memory presents data within its limit after drive enable falls.
// R13: Memory may drive immediately once drive enable falls.
// R14: Memory floats data within its limit after drive enable rises.
// R15: Memory holds old data briefly after address changes.
// R16: Write cycle minimum; address stable before write end; zero setup and recovery.
// R17: Write data valid before write end, removable right after.
// R18: Memory drives again only after a delay following write end.
// R19: Memory floats outputs within its limit after strobe falls.
// R20: Memory holds 512K bytes, 19 address and 8 data lines.
// R21: Memory needs no clock or refresh.
// R22: Deselected memory floats its data lines.
// R23: Selected with strobe and drive enable high, memory is idle.
`timescale 1ns/1ps
`default_nettype none
module sram_host
  import sram_host_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire req_t              req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic      [DATA_W-1:0] rd_data,
  output pins_t                  pins,
  input  wire logic [DATA_W-1:0] byte_lines_in,
  output logic      [DATA_W-1:0] byte_lines_out,
  output logic                   byte_lines_oe
);

  state_t            state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  pins_t             next_pins;
  logic [DATA_W-1:0] next_out, next_rd_data;
  logic              next_oe, next_ready, next_rd_valid;
  logic [DATA_W-1:0] bus_sync;
  logic              take;
  logic              cnt_last;
  logic              cnt_spent;

  // Read data crosses from the pins; its lag is part of the read wait
  pin_sync #(.W(DATA_W)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  (byte_lines_in),
    .dout (bus_sync)
  );

  assign take      = req_valid && req_ready;
  assign cnt_last  = (cnt == CNT_LAST);
  // Also true at zero, so a stray count cannot wrap and stall
  assign cnt_spent = (cnt <= CNT_LAST);

  // Sequencer: state and wait counter
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE: begin
        if (take) begin
          if (req.write) begin
            next_cnt   = CNT_W'(STROBE_HIZ_CYC);
            next_state = ST_WSET;
          end else begin
            next_cnt   = CNT_W'(READ_WAIT_CYC); // R9
            next_state = ST_RD;
          end
        end
      end
      ST_RD: begin
        next_cnt = cnt - CNT_STEP;
        if (cnt_last) begin
          next_cnt   = CNT_W'(FLOAT_WAIT_CYC); // R11 R14
          next_state = ST_FLOAT;
        end
      end
      ST_WSET: begin
        next_cnt = cnt - CNT_STEP;
        if (cnt_last) begin
          next_cnt   = CNT_W'(PULSE_LOAD_CYC); // R4 R5 R17
          next_state = ST_WPUL;
        end
      end
      ST_WPUL: begin
        next_cnt = cnt - CNT_STEP;
        if (cnt_last) begin
          next_cnt   = '0;
          next_state = ST_WEND;
        end
      end
      ST_WEND: begin
        // Pads the cycle so back-to-back writes keep the cycle minimum
        next_cnt   = CNT_W'(CYCLE_MIN_CYC); // R16
        next_state = ST_FLOAT;
      end
      ST_FLOAT: begin
        next_cnt = cnt - CNT_STEP;
        if (cnt_spent) begin
          next_cnt   = '0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_cnt   = '0;
        next_state = ST_IDLE;
      end
    endcase
  end

  // Memory control pins
  always_comb begin
    next_pins = pins;
    case (state)
      ST_IDLE: begin
        next_pins.select_n   = 1'b1;
        next_pins.strobe_n   = 1'b1;
        next_pins.drive_en_n = 1'b1;
        if (take) begin
          next_pins.addr_lines = req.addr; // R3 R16
          next_pins.select_n   = 1'b0;
          if (req.write) begin
            // Strobe falls with select so memory never drives R7 R1
            next_pins.strobe_n = 1'b0;
          end else begin
            next_pins.strobe_n   = 1'b1; // R2
            next_pins.drive_en_n = 1'b0;
          end
        end
      end
      ST_RD: begin
        if (cnt_last) begin
          next_pins.select_n   = 1'b1;
          next_pins.drive_en_n = 1'b1;
        end
      end
      ST_WSET: begin
        next_pins.strobe_n = 1'b0; // R1
      end
      ST_WPUL: begin
        if (cnt_last) begin
          // Select and strobe held together well past minimum R8 R16
          next_pins.strobe_n = 1'b1;
          next_pins.select_n = 1'b1;
        end
      end
      ST_WEND: begin
        next_pins.strobe_n = 1'b1;
        next_pins.select_n = 1'b1;
      end
      ST_FLOAT: begin
        next_pins.strobe_n   = 1'b1;
        next_pins.select_n   = 1'b1;
        next_pins.drive_en_n = 1'b1;
      end
      default: begin
        next_pins.select_n   = 1'b1;
        next_pins.strobe_n   = 1'b1;
        next_pins.drive_en_n = 1'b1;
      end
    endcase
  end

  // Host data drive
  always_comb begin
    next_out = byte_lines_out;
    next_oe  = byte_lines_oe;
    case (state)
      ST_IDLE: begin
        next_oe = 1'b0;
        if (take && req.write) begin
          next_out = req.wdata;
        end
      end
      ST_RD: begin
        next_oe = 1'b0; // R6
      end
      ST_WSET: begin
        // Hold data off until memory is surely floated R6 R19
        if (cnt_last) begin
          next_oe = 1'b1;
        end
      end
      ST_WPUL: begin
        next_oe = 1'b1; // R17
      end
      ST_WEND: begin
        // Data held one cycle past end, zero hold needed R17
        next_oe  = 1'b0;
        next_out = DATA_IDLE;
      end
      ST_FLOAT: begin
        next_oe = 1'b0;
      end
      default: begin
        next_oe  = 1'b0;
        next_out = DATA_IDLE;
      end
    endcase
  end

  // Read return
  always_comb begin
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    case (state)
      ST_RD: begin
        if (cnt_last) begin
          // Sample after access time plus synchroniser lag R9
          next_rd_data  = bus_sync;
          next_rd_valid = 1'b1;
        end
      end
      default: begin
        next_rd_valid = 1'b0;
      end
    endcase
  end

  // Request handshake
  always_comb begin
    next_ready = 1'b0;
    case (state)
      ST_IDLE: begin
        // Drops at once after a take: one request at a time
        next_ready = !take;
      end
      ST_FLOAT: begin
        next_ready = cnt_spent;
      end
      default: begin
        next_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Idle levels: deselected, no strobe, outputs disabled
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pins <= '{select_n: 1'b1, strobe_n: 1'b1, drive_en_n: 1'b1, addr_lines: ADDR_IDLE};
    end else begin
      pins <= next_pins;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      byte_lines_out <= DATA_IDLE;
      byte_lines_oe  <= 1'b0;
    end else begin
      byte_lines_out <= next_out;
      byte_lines_oe  <= next_oe;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data  <= DATA_IDLE;
    end else begin
      rd_valid <= next_rd_valid;
      rd_data  <= next_rd_data;
    end
  end

  // Ready stays low through reset so no request is taken early
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= next_ready;
    end
  end

endmodule // sram_host
`default_nettype wire

// *** design/sram_host_pkg.sv ***
/*
  Shared types and timing constants for the asynchronous byte memory host.
  Assumes a single 125 MHz clock; all pin times but select low-Z and write recovery are converted to cycles here.
*/
package sram_host_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 8000;

  // Times in ps, fastest grade
  localparam int READ_CYCLE_PS           = 10000;
  localparam int ADDR_ACCESS_PS          = 10000;
  localparam int SELECT_LOW_Z_PS         = 4000;
  localparam int DESELECT_TO_FLOAT_PS    = 5000;
  localparam int DRIVE_DISABLE_TO_FLOAT_PS = 5000;
  localparam int WRITE_CYCLE_PS          = 10000;
  localparam int WRITE_PULSE_PS          = 8000;
  localparam int STROBE_TO_FLOAT_PS      = 6000;
  localparam int DATA_SETUP_PS           = 6000;
  localparam int WRITE_RECOVERY_PS       = 0;

  function automatic int min_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Least times round up
  // Three sync flops plus the agreement register trail the pins
  localparam int SYNC_LAG_CYC    = 4;
  localparam int READ_WAIT_CYC   = min_cycles(ADDR_ACCESS_PS) + SYNC_LAG_CYC;
  localparam int FLOAT_WAIT_CYC  = min_cycles(DESELECT_TO_FLOAT_PS > DRIVE_DISABLE_TO_FLOAT_PS ?
                                              DESELECT_TO_FLOAT_PS : DRIVE_DISABLE_TO_FLOAT_PS);
  localparam int STROBE_HIZ_CYC  = min_cycles(STROBE_TO_FLOAT_PS);
  localparam int PULSE_CYC       = min_cycles(STROBE_TO_FLOAT_PS + DATA_SETUP_PS) > min_cycles(WRITE_PULSE_PS) ?
                                   min_cycles(STROBE_TO_FLOAT_PS + DATA_SETUP_PS) : min_cycles(WRITE_PULSE_PS);
  localparam int CYCLE_MIN_CYC   = min_cycles(WRITE_CYCLE_PS > READ_CYCLE_PS ? WRITE_CYCLE_PS : READ_CYCLE_PS);
  localparam int CNT_W           = 4;
  localparam int PULSE_LOAD_CYC  = PULSE_CYC - STROBE_HIZ_CYC + 1;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

  localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 19'h00000;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic              select_n;
    logic              strobe_n;
    logic              drive_en_n;
    logic [ADDR_W-1:0] addr_lines;
  } pins_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RD    = 6'h02,
    ST_WSET  = 6'h04,
    ST_WPUL  = 6'h08,
    ST_WEND  = 6'h10,
    ST_FLOAT = 6'h20
  } state_t;

endpackage

// *** test/sram_host_checker.sv ***
/* Pin-timing and handshake assertions for the memory host.
   Assumes one 125 MHz clock; bound to the host below. */
`timescale 1ns/1ps
`default_nettype none
module sram_host_checker
  import sram_host_pkg::*;
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              rd_valid,
  input wire pins_t             pins,
  input wire logic [DATA_W-1:0] byte_lines_out,
  input wire logic              byte_lines_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_READ_NO_STROBE: assert property (!pins.select_n && !pins.drive_en_n |-> pins.strobe_n)
    else $error("strobe low in read");
  AST_NO_CONTENTION: assert property (byte_lines_oe |-> pins.drive_en_n)
    else $error("host drives while memory enabled");
  AST_ADDR_HELD: assert property (!pins.select_n && $past(!pins.select_n) |-> $stable(pins.addr_lines))
    else $error("address moved while selected");
  AST_WDATA_HELD: assert property (!pins.strobe_n && $past(!pins.strobe_n) |-> $stable(byte_lines_out))
    else $error("write data moved in pulse");
  AST_DATA_SETUP: assert property ($rose(pins.strobe_n) |-> $past(byte_lines_oe))
    else $error("data not set before write end");
  AST_SELECT_WITH_STROBE: assert property ($fell(pins.strobe_n) |-> $fell(pins.select_n))
    else $error("strobe fell without select");
  AST_READ_MIN: assert property ($fell(pins.select_n) && pins.strobe_n |-> !pins.select_n[*2])
    else $error("read cycle short");
  AST_ENABLE_SELECTED: assert property (!pins.drive_en_n |-> !pins.select_n)
    else $error("drive enable without select");
  AST_TURNAROUND: assert property ($rose(byte_lines_oe) |-> $past(pins.drive_en_n, 2))
    else $error("host drove too soon after read");
  AST_TAKE_ONCE: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready held after take");
  AST_RD_PULSE: assert property (rd_valid |=> !rd_valid)
    else $error("read pulse too long");
  COV_READ: cover property (rd_valid);
  COV_WRITE: cover property ($rose(pins.strobe_n));
  COV_TURN: cover property ($rose(byte_lines_oe));
endmodule // sram_host_checker
bind sram_host sram_host_checker chk (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
  .rd_valid(rd_valid), .pins(pins), .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));
`default_nettype wire

// *** test/sram_model.sv ***
/* Behavioural byte memory at the host's far side.
   Assumes the bench resolves the shared data wire. */
`timescale 1ns/1ps
`default_nettype none
module sram_model
  import sram_host_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_lines,
  input  wire logic              select_n,
  input  wire logic              strobe_n,
  input  wire logic              drive_en_n,
  input  wire logic [DATA_W-1:0] wire_data,
  output logic      [DATA_W-1:0] data_out
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] last = 8'h00;
  logic              drv;
  logic              shown = 1'b0;
  always @(select_n, strobe_n, addr_lines, wire_data)
    if (!select_n && !strobe_n) mem[addr_lines] = wire_data;
  assign drv = !select_n && strobe_n && !drive_en_n;
  always @(drv, addr_lines)
    if (drv) last = mem.exists(addr_lines) ? mem[addr_lines] : 8'hA5;
  // Data shows only after the access time, so an early sample reads the inverse
  always @(drv) begin
    if (drv !== 1'b1) begin
      shown = 1'b0;
    end else begin
      #(ADDR_ACCESS_PS / 1000.0);
      shown = drv;
    end
  end
  // Released wire shows the inverse, never a stale match
  assign data_out = shown ? last : ~last;
endmodule // sram_model
`default_nettype wire

// *** test/testbench.sv ***
/* Self-checking bench: host, memory model, checker.
   Assumes the host's one-request handshake. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sram_host_pkg::*;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic              req_valid = 1'b0;
  req_t              req = '0;
  logic              req_ready, rd_valid, byte_lines_oe;
  logic [DATA_W-1:0] rd_data, byte_lines_out, mem_out, byte_lines_in;
  pins_t             pins;
  int                error_cnt = 0;
  int                n_tests = 0;
  assign byte_lines_in = byte_lines_oe ? byte_lines_out : mem_out;
  sram_host dut (.mclk(mclk), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .byte_lines_in(byte_lines_in),
    .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));
  sram_model mem (.addr_lines(pins.addr_lines), .select_n(pins.select_n), .strobe_n(pins.strobe_n),
    .drive_en_n(pins.drive_en_n), .wire_data(byte_lines_in), .data_out(mem_out));
  initial forever #4 mclk = ~mclk;
  task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    req = '{write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n++ < 50) @(negedge mclk);
    check("req_ready", 8'h01, {7'h00, req_ready});
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    issue(1'b0, a, 8'h00);
    while (rd_valid !== 1'b1 && n++ < 20) @(negedge mclk);
    check("rd_valid", 8'h01, {7'h00, rd_valid});
    check("rd_data", exp, rd_data);
  endtask
  task automatic t_idle;
    check("idle ctrl", 8'h07, {5'h00, pins.select_n, pins.strobe_n, pins.drive_en_n});
    check("idle oe", 8'h00, {7'h00, byte_lines_oe});
  endtask
  // Lowest and highest byte, then reads back to back
  task automatic t_corners;
    issue(1'b1, 19'h00000, 8'h5A);
    issue(1'b1, 19'h7FFFF, 8'hC3);
    rd(19'h00000, 8'h5A);
    rd(19'h7FFFF, 8'hC3);
  endtask
  task automatic t_overwrite;
    issue(1'b1, 19'h2AAAA, 8'h11);
    issue(1'b1, 19'h2AAAA, 8'hEE);
    rd(19'h2AAAA, 8'hEE);
    rd(19'h15555, 8'hA5);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_idle();
    t_corners();
    t_overwrite();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
